// ---- shared/acs_pkg.sv ----
// constants shared by both ends of the converter control link
package acs_pkg;
  localparam int FRAME_BITS = 16;
  localparam int MUX_EDGE = 14;
  localparam int DATA_BITS = 12;
  // control word bit positions, reset values and power mode codes
  localparam int WR_BIT = 15;
  localparam int SEQ_BIT = 14;
  localparam int ADDR_LSB = 10;
  localparam int PM_LSB = 8;
  localparam int SHADOW_BIT = 7;
  localparam int RANGE_BIT = 5;
  localparam int CODING_BIT = 4;
  localparam int CTRL_LSB = 4;
  localparam logic [10:0] CTRL_RESET = 11'h030;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [1:0] PM_NORMAL = 2'h3;
  localparam logic [1:0] PM_FULL_DOWN = 2'h2;
  localparam logic [1:0] PM_AUTO_DOWN = 2'h1;
  localparam logic [1:0] PM_INVALID = 2'h0;
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int WAKE_TIME_NS = 1000;
  localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) /
                               CLK_PERIOD_NS;
  localparam int SCLK_HALF = 4;
  // host register map
  localparam logic [3:0] CMD_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] RXDATA_OFFSET = 4'h8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_REFUSED_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- shared/acs_link_if.sv ----
// serial link between host controller and converter
`timescale 1ns/1ps
interface acs_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  modport dev (input cs_n, input sclk, input din, output dout);
  modport host (output cs_n, output sclk, output din, input dout);
endinterface

// ---- logic/acs_adc_dev.sv ----
// converter end: control word, sequencer, power mode and mask register
`timescale 1ns/1ps
module acs_adc_dev
  import acs_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // serial link
  acs_link_if.dev link,
  // converter side
  input wire logic [DATA_BITS-1:0] conv_data,
  output logic conv_start,
  output logic [2:0] mux_channel,
  output logic powered_up,
  output logic range_sel,
  output logic coding_sel,
  output logic [15:0] channel_sequence_mask
);
  typedef enum {RUN_NONE, RUN_SHADOW, RUN_CONSEC} acs_run_t;

  logic [2:0] cs_q;
  logic [2:0] sclk_q;
  logic [1:0] din_q;
  logic [4:0] edge_cnt_reg;
  logic [15:0] rx_reg;
  logic [15:0] tx_reg;
  logic [10:0] ctrl_reg;
  logic [15:0] mask_reg;
  logic shadow_pend_reg;
  acs_run_t run_reg;
  acs_run_t run_next;
  logic [3:0] pos_reg;
  logic [3:0] pos_next;
  logic [2:0] chan_reg;
  logic [2:0] chan_next;
  logic auto_sleep_reg;
  logic conv_start_reg;

  // ascending search for the next marked slot, wrapping
  function automatic logic [3:0] next_pos(input logic [15:0] m,
                                          input logic [3:0] p);
    logic [3:0] q;
    logic [3:0] r;
    r = p;
    for (int k = 16; k >= 1; k--) begin
      q = p + 4'(k);
      if (m[4'hF - q]) r = q;
    end
    return r;
  endfunction

  // edge detection on synchronised pins
  wire cs_fall = cs_q[2] & ~cs_q[1];
  wire sclk_fall = ~cs_q[1] & sclk_q[2] & ~sclk_q[1];
  wire din_bit = din_q[1];
  wire mux_edge = sclk_fall && edge_cnt_reg == 5'(MUX_EDGE - 1);
  wire last_edge = sclk_fall && edge_cnt_reg == 5'(FRAME_BITS - 1);

  // word as seen at the mux edge and at the last edge
  wire [15:0] w14 = {rx_reg[12:0], din_bit, 2'b00};
  wire [15:0] w16 = {rx_reg[14:0], din_bit};

  // current control fields
  wire [1:0] cur_pm = ctrl_reg[PM_LSB-CTRL_LSB +: 2];
  wire [2:0] cur_addr = ctrl_reg[ADDR_LSB-CTRL_LSB +: 3];
  // frames without commit keep any running sequence
  wire [1:0] keep_mode = 2'b10;
  wire [1:0] new_pm = w16[PM_LSB +: 2];
  wire new_shadow_req = ~w16[SEQ_BIT] & w16[SHADOW_BIT];

  // effective mode and address after the transfer in progress
  wire wr14 = w14[WR_BIT];
  wire [1:0] eff_mode = wr14 ? {w14[SEQ_BIT], w14[SHADOW_BIT]} : keep_mode;
  wire [2:0] eff_addr = wr14 ? w14[ADDR_LSB +: 3] : cur_addr;
  wire [3:0] shadow_step = next_pos(mask_reg, pos_reg);
  wire [2:0] consec_step = (chan_reg >= eff_addr) ? 3'h0 :
                           3'(chan_reg + 3'h1);
  wire [3:0] first_slot = next_pos(w16, 4'hF);

  always_comb begin
    run_next = RUN_NONE;
    pos_next = pos_reg;
    chan_next = eff_addr;
    case (eff_mode)
      2'b10: begin
        run_next = run_reg;
        if (run_reg == RUN_SHADOW) begin
          pos_next = shadow_step;
          chan_next = shadow_step[2:0];
        end else if (run_reg == RUN_CONSEC) begin
          chan_next = consec_step;
        end
      end
      2'b11: begin
        run_next = RUN_CONSEC;
        chan_next = (run_reg == RUN_CONSEC) ? consec_step : 3'h0;
      end
      default: begin
        run_next = RUN_NONE;
      end
    endcase
  end

  // pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_q <= 3'h7;
      sclk_q <= 3'h7;
      din_q <= 2'h0;
    end else begin
      cs_q <= {cs_q[1:0], link.cs_n};
      sclk_q <= {sclk_q[1:0], link.sclk};
      din_q <= {din_q[0], link.din};
    end
  end

  // frame bit counter and shift registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_cnt_reg <= 5'h00;
      rx_reg <= 16'h0000;
      tx_reg <= 16'h0000;
    end else if (cs_fall) begin
      edge_cnt_reg <= 5'h00;
      tx_reg <= {1'b0, chan_reg, conv_data};
    end else if (sclk_fall) begin
      edge_cnt_reg <= 5'(edge_cnt_reg + 5'h01);
      rx_reg <= w16;
      tx_reg <= {tx_reg[14:0], 1'b0};
    end
  end

  // channel selection at the mux edge, first marked mask slot at the end of a mask frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_reg <= 3'h0;
      pos_reg <= 4'h0;
      run_reg <= RUN_NONE;
    end else if (last_edge && shadow_pend_reg) begin
      pos_reg <= first_slot;
      chan_reg <= first_slot[2:0];
      run_reg <= RUN_SHADOW;
    end else if (mux_edge && !shadow_pend_reg) begin
      chan_reg <= chan_next;
      pos_reg <= pos_next;
      run_reg <= run_next;
    end
  end

  // control word and mask register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      mask_reg <= MASK_RESET;
      shadow_pend_reg <= 1'b0;
    end else if (last_edge) begin
      if (shadow_pend_reg) begin
        mask_reg <= w16;
        shadow_pend_reg <= 1'b0;
      end else if (w16[WR_BIT]) begin
        ctrl_reg <= w16[SEQ_BIT:CTRL_LSB];
        shadow_pend_reg <= new_shadow_req;
      end
    end
  end

  // power state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_sleep_reg <= 1'b0;
      conv_start_reg <= 1'b0;
    end else begin
      conv_start_reg <= cs_fall && cur_pm != PM_FULL_DOWN;
      if (last_edge && !shadow_pend_reg && w16[WR_BIT])
        auto_sleep_reg <= new_pm == PM_AUTO_DOWN;
      else if (cs_fall)
        auto_sleep_reg <= 1'b0;
    end
  end

  assign link.dout = tx_reg[15];
  assign conv_start = conv_start_reg;
  assign mux_channel = chan_reg;
  assign powered_up = (cur_pm == PM_NORMAL) ||
                      (cur_pm == PM_AUTO_DOWN && !auto_sleep_reg);
  assign range_sel = ctrl_reg[RANGE_BIT-CTRL_LSB];
  assign coding_sel = ctrl_reg[CODING_BIT-CTRL_LSB];
  assign channel_sequence_mask = mask_reg;
endmodule

// ---- logic/acs_host.sv ----
// host end: AXI4-Lite command registers driving the serial link
`timescale 1ns/1ps
module acs_host
  import acs_pkg::*;
#(
  parameter int HALF_CYCLES = SCLK_HALF,
  parameter int GAP_CYCLES = WAKE_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // serial link
  acs_link_if.host link
);
  typedef enum {ST_IDLE, ST_LEAD, ST_SHIFT, ST_GAP} acs_state_t;

  acs_state_t state_reg;
  logic [15:0] cnt_reg;
  logic [3:0] bit_reg;
  logic [15:0] tx_reg;
  logic [15:0] rx_reg;
  logic cs_n_reg;
  logic sclk_reg;
  logic din_reg;
  logic [1:0] dout_q;
  logic mask_next_reg;
  logic refused_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [3:0] awaddr_reg;
  logic [15:0] wdata_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  wire busy = state_reg != ST_IDLE;
  wire do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire cmd_hit = awaddr_reg == CMD_OFFSET;
  wire bad_pm = !mask_next_reg && wdata_reg[WR_BIT] &&
                wdata_reg[PM_LSB +: 2] == PM_INVALID;
  wire cmd_ok = do_write && cmd_hit && !busy && !bad_pm;
  wire cmd_bad = do_write && cmd_hit && (busy || bad_pm);
  wire half_done = cnt_reg == 16'(HALF_CYCLES - 1);
  wire ar_take = arvalid & ~rvalid_reg;
  wire rd_cmd = araddr == CMD_OFFSET;
  wire rd_stat = araddr == STATUS_OFFSET;
  wire rd_rx = araddr == RXDATA_OFFSET;
  wire [31:0] stat_word = {30'h0, refused_reg, busy};
  wire [31:0] rd_word = rd_stat ? stat_word :
                        rd_rx ? {16'h0, rx_reg} :
                        rd_cmd ? {16'h0, wdata_reg} : 32'h0;

  assign awready = ~aw_held_reg & ~bvalid_reg;
  assign wready = ~w_held_reg & ~bvalid_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = ~rvalid_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign link.cs_n = cs_n_reg;
  assign link.sclk = sclk_reg;
  assign link.din = din_reg;

  // write channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 16'h0000;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= {wstrb[1] ? wdata[15:8] : 8'h00,
                      wstrb[0] ? wdata[7:0] : 8'h00};
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= cmd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= (rd_cmd || rd_stat || rd_rx) ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // command bookkeeping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refused_reg <= 1'b0;
      mask_next_reg <= 1'b0;
    end else if (cmd_bad) begin
      refused_reg <= 1'b1;
    end else if (cmd_ok) begin
      refused_reg <= 1'b0;
      mask_next_reg <= !mask_next_reg && wdata_reg[WR_BIT] &&
                       !wdata_reg[SEQ_BIT] && wdata_reg[SHADOW_BIT];
    end
  end

  // link sequencer: sclk idles high, falls to shift
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dout_q <= 2'h0;
      state_reg <= ST_IDLE;
      cnt_reg <= 16'h0000;
      bit_reg <= 4'h0;
      tx_reg <= 16'h0000;
      rx_reg <= 16'h0000;
      cs_n_reg <= 1'b1;
      sclk_reg <= 1'b1;
      din_reg <= 1'b0;
    end else begin
      dout_q <= {dout_q[0], link.dout};
      cnt_reg <= 16'(cnt_reg + 16'h0001);
      case (state_reg)
        ST_IDLE: begin
          cnt_reg <= 16'h0000;
          if (cmd_ok) begin
            state_reg <= ST_LEAD;
            tx_reg <= wdata_reg;
            din_reg <= wdata_reg[15];
            cs_n_reg <= 1'b0;
            bit_reg <= 4'h0;
          end
        end
        ST_LEAD: begin
          if (half_done) begin
            state_reg <= ST_SHIFT;
            cnt_reg <= 16'h0000;
          end
        end
        ST_SHIFT: begin
          if (half_done) begin
            cnt_reg <= 16'h0000;
            sclk_reg <= ~sclk_reg;
            if (sclk_reg) begin
              rx_reg <= {rx_reg[14:0], dout_q[1]};
            end else if (bit_reg == 4'hF) begin
              state_reg <= ST_GAP;
              cs_n_reg <= 1'b1;
            end else begin
              bit_reg <= 4'(bit_reg + 4'h1);
              tx_reg <= {tx_reg[14:0], 1'b0};
              din_reg <= tx_reg[14];
            end
          end
        end
        ST_GAP: begin
          if (cnt_reg == 16'(GAP_CYCLES - 1))
            state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule

// ---- dv/acs_checker_sva.sv ----
// link and converter-side assertions for the control link
`timescale 1ns/1ps
module acs_checker_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // serial link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  // converter side
  input wire logic conv_start,
  input wire logic powered_up,
  input wire logic [2:0] mux_channel,
  input wire logic [15:0] channel_sequence_mask
);
  logic sclk_q;
  logic fall;
  logic [4:0] fcnt;
  assign fall = sclk_q & ~sclk;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_q <= 1'b1;
      fcnt <= 5'h00;
    end else begin
      sclk_q <= sclk;
      if ($fell(cs_n)) begin
        fcnt <= 5'h00;
      end else if (fall) begin
        fcnt <= fcnt + 5'h01;
      end
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sclk_idle_a: assert property (cs_n |-> sclk)
    else $error("serial clock low outside frame");
  lead_time_a: assert property ($fell(cs_n) |-> sclk [*8] ##1 !sclk)
    else $error("first clock fall not 8 cycles after select");
  frame_edges_a: assert property ($rose(cs_n) |-> fcnt == 5'h10)
    else $error("frame did not carry 16 clock falls");
  din_hold_a: assert property (!cs_n && !$fell(cs_n) && $changed(din)
    |-> $rose(sclk))
    else $error("data changed away from clock rise");
  dout_lead_a: assert property (fall && !cs_n && fcnt == 5'h00 |-> !dout)
    else $error("leading output bit not zero");
  mux_edge_a: assert property ($changed(mux_channel) |-> fcnt >= 5'h0E)
    else $error("mux moved before fourteenth fall");
  mask_load_a: assert property ($changed(channel_sequence_mask)
    |-> fcnt == 5'h10)
    else $error("mask changed outside a full frame");
  conv_pulse_a: assert property (conv_start |-> !cs_n ##1 !conv_start)
    else $error("conversion start not a single pulse in frame");
  conv_power_a: assert property (conv_start |-> powered_up)
    else $error("conversion started while powered down");
endmodule

// ---- dv/adc_channel_sequencer_power_ctrl_tb_top.sv ----
// testbench joining host and converter ends over the link
`timescale 1ns/1ps
module adc_channel_sequencer_power_ctrl_tb_top;
  import acs_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic conv_start, powered_up, range_sel, coding_sel;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [2:0] mux_channel, prev, m;
  logic [15:0] channel_sequence_mask;
  logic [15:0] tw [8] = '{16'h9730, 16'h0B30, 16'h8380, 16'h2440,
                          16'h0000, 16'h0000, 16'hC320, 16'h0000};
  logic [2:0] te [8] = '{3'h5, 3'h5, 3'h0, 3'h2, 3'h5, 3'h1, 3'h2, 3'h5};
  logic [1:0] trc [8] = '{2'h3, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2};
  int n_fail, check_count, conv_cnt, c, i;
  acs_link_if link();
  acs_host acs_host_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .link(link));
  acs_adc_dev acs_adc_dev_i (.aclk(aclk), .aresetn(aresetn), .link(link),
    .conv_data(12'hABC), .conv_start(conv_start), .mux_channel(mux_channel),
    .powered_up(powered_up), .range_sel(range_sel), .coding_sel(coding_sel),
    .channel_sequence_mask(channel_sequence_mask));
  acs_checker_sva acs_checker_sva_i (.aclk(aclk), .aresetn(aresetn),
    .cs_n(link.cs_n), .sclk(link.sclk), .din(link.din), .dout(link.dout),
    .conv_start(conv_start), .powered_up(powered_up),
    .mux_channel(mux_channel),
    .channel_sequence_mask(channel_sequence_mask));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (conv_start === 1'b1) conv_cnt++;
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v,
                    output logic [1:0] rs);
    logic ta, tv, tb;
    tb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tv = wvalid & wready;
      tb = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tv) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    logic ta, tr;
    tr = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask
  task automatic send(input logic [15:0] w);
    logic [1:0] rs;
    logic [31:0] v;
    wr(CMD_OFFSET, w, rs);
    chk("bresp", 32'(rs), 32'(RESP_OKAY));
    v = 32'h1;
    while (v[STAT_BUSY_BIT] !== 1'b0) rd(STATUS_OFFSET, v, rs);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    n_fail++;
    test_done();
  end
  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(STATUS_OFFSET, d, r);
    chk("status", d, 32'h0);
    chk("mux", 32'(mux_channel), 32'h0);
    chk("power", 32'(powered_up), 32'h1);
    chk("mask", 32'(channel_sequence_mask), 32'(MASK_RESET));
    wr(4'hC, 16'h1234, r);
    chk("wresp", 32'(r), 32'(RESP_SLVERR));
    rd(4'hC, d, r);
    chk("rresp", 32'(r), 32'(RESP_SLVERR));
    chk("rdata", d, 32'h0);
    prev = 3'h0;
    for (i = 0; i < 8; i++) begin
      send(tw[i]);
      chk("mux", 32'(mux_channel), 32'(te[i]));
      chk("ctrl", 32'({range_sel, coding_sel}), 32'(trc[i]));
      rd(RXDATA_OFFSET, d, r);
      chk("rx", d, {16'h0, 1'b0, prev, 12'hABC});
      prev = te[i];
      if (i == 3) chk("mask", 32'(channel_sequence_mask), 32'h2440);
    end
    send(16'hCF80);
    m = mux_channel;
    for (i = 0; i < 4; i++) begin
      send(16'h0000);
      m = (m >= 3'h3) ? 3'h0 : m + 3'h1;
      chk("mux", 32'(mux_channel), 32'(m));
    end
    send(16'h9B00);
    chk("mux", 32'(mux_channel), 32'h6);
    send(16'h0000);
    chk("mux", 32'(mux_channel), 32'h6);
    send(16'h8200);
    chk("power", 32'(powered_up), 32'h0);
    c = conv_cnt;
    send(16'h0200);
    chk("conv", 32'(conv_cnt - c), 32'h0);
    chk("power", 32'(powered_up), 32'h0);
    send(16'h8100);
    chk("power", 32'(powered_up), 32'h0);
    c = conv_cnt;
    send(16'h0100);
    chk("conv", 32'(conv_cnt - c), 32'h1);
    send(16'h8300);
    chk("power", 32'(powered_up), 32'h1);
    c = conv_cnt;
    send(16'h0300);
    chk("conv", 32'(conv_cnt - c), 32'h1);
    wr(CMD_OFFSET, 16'h9C00, r);
    chk("bresp", 32'(r), 32'(RESP_OKAY));
    rd(STATUS_OFFSET, d, r);
    chk("status", d, 32'h2);
    chk("mux", 32'(mux_channel), 32'h0);
    rd(CMD_OFFSET, d, r);
    chk("cmd", d, 32'h9C00);
    test_done();
  end
endmodule
